// ===== logic/pats_pkg.sv
// Constants, register map and reset values of the PWM / converter trigger block
package pats_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEADTIME_NS = 500;
  localparam int DEADTIME_CYC = (DEADTIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRETRIG0_CYC = DEADTIME_CYC / 2;
  localparam int SPI_HZ = 3_120_000;
  localparam int SPI_HALF_CYC = CLK_HZ / (2 * SPI_HZ);
  localparam int ADC_NORM_HZ = 24_000_000;
  localparam int ADC_CAL_HZ = 6_000_000;
  localparam logic [4:0] ADC_DIV_NORM = 5'(CLK_HZ / ADC_NORM_HZ);
  localparam logic [4:0] ADC_DIV_CAL = 5'(CLK_HZ / ADC_CAL_HZ);
  localparam logic [5:0] AVG_CAL = 6'h20;
  localparam logic [5:0] AVG_NORM = 6'h01;
  localparam int FILT_SAMPLES = 4;
  localparam int SLOW_PRESCALE = 16;
  localparam int SLOW_RATIO = 10;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] START_RST = 16'hf448;
  localparam logic [15:0] END_RST = 16'h0bb7;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [15:0] IDLY_RST = 16'h2328;
  localparam logic [15:0] CTRL_RST = 16'h01d1;
  localparam logic [7:0] MASK_RST = 8'hc0;
  localparam logic [5:0] DAC_RST = 6'h3e;
  localparam int PWM_MODULO = int'($signed(END_RST)) - int'($signed(START_RST)) + 1;
  localparam int SLOW_MOD = PWM_MODULO / SLOW_PRESCALE * SLOW_RATIO;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_START = 8'h04;
  localparam logic [7:0] OFS_END = 8'h08;
  localparam logic [7:0] OFS_DUTY0 = 8'h0c;
  localparam logic [7:0] OFS_DUTY1 = 8'h10;
  localparam logic [7:0] OFS_DUTY2 = 8'h14;
  localparam logic [7:0] OFS_DEAD = 8'h18;
  localparam logic [7:0] OFS_PT0 = 8'h1c;
  localparam logic [7:0] OFS_IDLY = 8'h20;
  localparam logic [7:0] OFS_MASK = 8'h24;
  localparam logic [7:0] OFS_DAC = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_SPI = 8'h30;
  localparam logic [3:0] RES_PAGE = 4'h4;

  // ==========================================================================
  // Control bits
  localparam int C_TRIG_EN = 0;
  localparam int C_FAULT_POL = 1;
  localparam int C_HS_POL = 2;
  localparam int C_LS_POL = 3;
  localparam int C_B2B = 4;
  localparam int C_CAL = 5;
  localparam int C_AUTO_CLR = 6;
  localparam int C_CMP_FLT = 7;
  localparam int C_PIN_FLT = 8;

  // Status flag bits
  localparam int F_SEQ = 0;
  localparam int F_DLY = 1;
  localparam int F_FAST = 2;
  localparam int F_SLOW = 3;
  localparam int F_FAULT = 4;

endpackage

// ===== logic/pats_top.sv
// PWM generator with delay block, converter pre-triggers, comparator filter and SPI
// Behaviour
// - Counter runs signed start to end value
// - Channels six and seven held inactive
// - Odd channel drives complement of even
// - Fault disables pairs, clears at reload
// - Dead time inserted at each pair
// - Fault and side polarities are selectable
// - Reload trigger pulses at period start
// - Reload trigger restarts delay block counter
// - Pre-trigger 0 after half dead time
// - Back-to-back pre-trigger 1 on completion
// - Converters start only on pre-triggers
// - Fast-loop interrupt on first completion
// - Sequence error on unread result
// - Delay interrupt at interrupt delay value
// - Shared request, readable error flag
// - Reference DAC code 62 of 64
// - Filter needs four agreeing samples
// - Slow timer prescaled, interrupts on its own wrap at SLOW_MOD
// - SPI master 3.12 MHz, select high
// - Calibration 6 MHz, averaging 32
module pats_top #(
  parameter int ADC_W = 12,
  parameter int SLOW_MOD = pats_pkg::SLOW_MOD,
  parameter logic [15:0] DEAD_RST = 16'(pats_pkg::DEADTIME_CYC)
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic fault_pin,
  input logic cmp_raw,
  output logic [5:0] dac_code,
  output logic [7:0] pwm_out,
  output logic reload_trigger,
  output logic [1:0] adc_start,
  output logic [1:0] adc_seq,
  input logic [1:0] adc_done,
  input logic [ADC_W-1:0] adc_data0,
  input logic [ADC_W-1:0] adc_data1,
  output logic [4:0] adc_clk_div,
  output logic [5:0] adc_avg_samples,
  output logic fast_loop_irq,
  output logic delay_irq,
  output logic slow_irq,
  output logic spi_sclk,
  output logic spi_mosi,
  output logic spi_cs1,
  input logic spi_miso
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] start;
    logic [15:0] end_v;
    logic [2:0][15:0] duty;
    logic [15:0] dead;
    logic [15:0] pt0;
    logic [15:0] idly;
    logic [7:0] mask;
    logic [5:0] dac;
    logic [3:0] flags;
    logic [31:0] prdata;
    logic err;
    logic [15:0] cnt;
    logic reload;
    logic trig;
    logic [2:0] raw;
    logic [2:0][15:0] dtc;
    logic [7:0] pwm;
    logic fault_lat;
    logic fault_s1;
    logic fault_s2;
    logic cmp_s1;
    logic cmp_s2;
    logic cmp_filt;
    logic [1:0] cmp_run;
    logic [15:0] dcnt;
    logic drun;
    logic [1:0] start_p;
    logic [1:0] seq;
    logic [3:0][ADC_W-1:0] res;
    logic [3:0] unread;
    logic [3:0] sdiv;
    logic [15:0] scnt;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [2:0] bitc;
    logic [4:0] sdv;
    logic busy;
    logic sclk;
    logic miso_s1;
    logic miso_s2;
  } pats_state_t;

  pats_state_t s_reg;
  pats_state_t s_next;
  logic fault_now;
  logic acc;
  logic [7:0] idle_pat;
  logic [ADC_W-1:0] conv_data [2];

  function automatic logic is_res(input logic [7:0] a);
    return (a[7:4] == pats_pkg::RES_PAGE) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic pin_lvl(input logic act, input logic pol_low);
    return act ^ pol_low;
  endfunction

  // ==========================================================================
  // Fault source and helpers
  // fault polarity applied
  assign fault_now = ((s_reg.fault_s2 ^ s_reg.ctrl[pats_pkg::C_FAULT_POL])
                      & s_reg.ctrl[pats_pkg::C_PIN_FLT])
                     | (s_reg.cmp_filt & s_reg.ctrl[pats_pkg::C_CMP_FLT]);
  assign acc = psel && penable;
  assign idle_pat = {4{s_reg.ctrl[pats_pkg::C_LS_POL], s_reg.ctrl[pats_pkg::C_HS_POL]}};
  assign conv_data[0] = adc_data0;
  assign conv_data[1] = adc_data1;

  // ==========================================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.reload = 1'b0;
    s_next.trig = 1'b0;
    s_next.start_p = 2'b00;
    s_next.fault_s1 = fault_pin;
    s_next.fault_s2 = s_reg.fault_s1;
    s_next.cmp_s1 = cmp_raw;
    s_next.cmp_s2 = s_reg.cmp_s1;
    s_next.miso_s1 = spi_miso;
    s_next.miso_s2 = s_reg.miso_s1;

    // Setup phase: capture read data and decode error
    if (psel && !penable) begin
      s_next.err = 1'b0;
      s_next.prdata = 32'h0000_0000;
      if (paddr == pats_pkg::OFS_CTRL) begin
        s_next.prdata = {16'h0000, s_reg.ctrl};
      end else if (paddr == pats_pkg::OFS_START) begin
        s_next.prdata = {16'h0000, s_reg.start};
      end else if (paddr == pats_pkg::OFS_END) begin
        s_next.prdata = {16'h0000, s_reg.end_v};
      end else if (paddr == pats_pkg::OFS_DUTY0) begin
        s_next.prdata = {16'h0000, s_reg.duty[0]};
      end else if (paddr == pats_pkg::OFS_DUTY1) begin
        s_next.prdata = {16'h0000, s_reg.duty[1]};
      end else if (paddr == pats_pkg::OFS_DUTY2) begin
        s_next.prdata = {16'h0000, s_reg.duty[2]};
      end else if (paddr == pats_pkg::OFS_DEAD) begin
        s_next.prdata = {16'h0000, s_reg.dead};
      end else if (paddr == pats_pkg::OFS_PT0) begin
        s_next.prdata = {16'h0000, s_reg.pt0};
      end else if (paddr == pats_pkg::OFS_IDLY) begin
        s_next.prdata = {16'h0000, s_reg.idly};
      end else if (paddr == pats_pkg::OFS_MASK) begin
        s_next.prdata = {24'h000000, s_reg.mask};
      end else if (paddr == pats_pkg::OFS_DAC) begin
        s_next.prdata = {26'h0000000, s_reg.dac};
      end else if (paddr == pats_pkg::OFS_STATUS) begin
        s_next.prdata = {25'h0000000, s_reg.busy, s_reg.cmp_filt, s_reg.fault_lat, s_reg.flags};
      end else if (paddr == pats_pkg::OFS_SPI) begin
        s_next.prdata = {23'h000000, s_reg.busy, s_reg.rx};
      end else if (is_res(paddr)) begin
        s_next.prdata = {{(32 - ADC_W){1'b0}}, s_reg.res[paddr[3:2]]};
      end else begin
        s_next.err = 1'b1;
      end
    end

    // Access phase writes
    if (acc && pwrite && !s_reg.err) begin
      if (paddr == pats_pkg::OFS_CTRL) begin
        s_next.ctrl = pwdata[15:0];
      end else if (paddr == pats_pkg::OFS_START) begin
        s_next.start = pwdata[15:0];
      end else if (paddr == pats_pkg::OFS_END) begin
        s_next.end_v = pwdata[15:0];
      end else if (paddr == pats_pkg::OFS_DUTY0) begin
        s_next.duty[0] = pwdata[15:0];
      end else if (paddr == pats_pkg::OFS_DUTY1) begin
        s_next.duty[1] = pwdata[15:0];
      end else if (paddr == pats_pkg::OFS_DUTY2) begin
        s_next.duty[2] = pwdata[15:0];
      end else if (paddr == pats_pkg::OFS_DEAD) begin
        s_next.dead = pwdata[15:0];
      end else if (paddr == pats_pkg::OFS_PT0) begin
        s_next.pt0 = pwdata[15:0];
      end else if (paddr == pats_pkg::OFS_IDLY) begin
        s_next.idly = pwdata[15:0];
      end else if (paddr == pats_pkg::OFS_MASK) begin
        s_next.mask = pwdata[7:0];
      end else if (paddr == pats_pkg::OFS_DAC) begin
        s_next.dac = pwdata[5:0];
      end else if (paddr == pats_pkg::OFS_STATUS) begin
        s_next.flags = s_reg.flags & ~pwdata[3:0];
        if (pwdata[pats_pkg::F_FAULT]) begin
          s_next.fault_lat = 1'b0;
        end
      end else if (paddr == pats_pkg::OFS_SPI && !s_reg.busy) begin
        s_next.tx = pwdata[7:0];
        s_next.busy = 1'b1;
        s_next.bitc = 3'h0;
        s_next.sdv = 5'h00;
        s_next.sclk = 1'b0;
      end
    end
    // Reading a result marks it consumed
    if (acc && !pwrite && is_res(paddr)) begin
      s_next.unread[paddr[3:2]] = 1'b0;
    end

    // period wrap from end to start value
    if ($signed(s_reg.cnt) >= $signed(s_reg.end_v)) begin
      s_next.cnt = s_reg.start;
      s_next.reload = 1'b1;
      s_next.trig = s_reg.ctrl[pats_pkg::C_TRIG_EN];
    end else begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end

    // fault latch, set wins over clear
    if (fault_now) begin
      s_next.fault_lat = 1'b1;
    end else if (s_reg.reload && s_reg.ctrl[pats_pkg::C_AUTO_CLR]) begin
      s_next.fault_lat = 1'b0;
    end

    // unused channels and masked ones inactive
    s_next.pwm = idle_pat;
    for (int i = 0; i < 3; i++) begin
      // dead time on every edge of a pair
      if (($signed(s_reg.cnt) < $signed(s_reg.duty[i])) != s_reg.raw[i]) begin
        s_next.raw[i] = ~s_reg.raw[i];
        s_next.dtc[i] = s_reg.dead;
      end else if (s_reg.dtc[i] != 16'h0000) begin
        s_next.dtc[i] = s_reg.dtc[i] - 16'h0001;
      end
      if (s_reg.dtc[i] == 16'h0000 && !s_reg.fault_lat && !fault_now) begin
        s_next.pwm[2 * i] = s_reg.mask[2 * i] ? idle_pat[2 * i]
          : pin_lvl(s_reg.raw[i], s_reg.ctrl[pats_pkg::C_HS_POL]);
        s_next.pwm[2 * i + 1] = s_reg.mask[2 * i + 1] ? idle_pat[2 * i + 1]
          : pin_lvl(~s_reg.raw[i], s_reg.ctrl[pats_pkg::C_LS_POL]);
      end
    end

    if (s_reg.trig) begin
      s_next.dcnt = 16'h0000;
      s_next.drun = 1'b1;
    end else if (s_reg.drun) begin
      s_next.dcnt = s_reg.dcnt + 16'h0001;
      if (s_reg.dcnt == s_reg.idly) begin
        s_next.flags[pats_pkg::F_DLY] = 1'b1;
        s_next.drun = 1'b0;
      end
    end

    for (int c = 0; c < 2; c++) begin
      if (adc_done[c]) begin
        s_next.res[2 * c + int'(s_reg.seq[c])] = conv_data[c];
        s_next.unread[2 * c + int'(s_reg.seq[c])] = 1'b1;
        if (!s_reg.seq[c]) begin
          if (c == 0) begin
            s_next.flags[pats_pkg::F_FAST] = 1'b1;
          end
          if (s_reg.ctrl[pats_pkg::C_B2B]) begin
            s_next.start_p[c] = 1'b1;
            s_next.seq[c] = 1'b1;
            if (s_reg.unread[2 * c + 1]) begin
              s_next.flags[pats_pkg::F_SEQ] = 1'b1;
            end
          end
        end
      end
      // first pre-trigger after half dead time
      if (s_reg.drun && s_reg.dcnt == s_reg.pt0) begin
        s_next.start_p[c] = 1'b1;
        s_next.seq[c] = 1'b0;
        if (s_reg.unread[2 * c]) begin
          s_next.flags[pats_pkg::F_SEQ] = 1'b1;
        end
      end
    end

    // four agreeing samples flip the filter
    if (s_reg.cmp_s2 == s_reg.cmp_filt) begin
      s_next.cmp_run = 2'h0;
    end else if (s_reg.cmp_run == 2'(pats_pkg::FILT_SAMPLES - 1)) begin
      s_next.cmp_filt = s_reg.cmp_s2;
      s_next.cmp_run = 2'h0;
    end else begin
      s_next.cmp_run = s_reg.cmp_run + 2'h1;
    end

    s_next.sdiv = s_reg.sdiv + 4'h1;
    if (s_reg.sdiv == 4'(pats_pkg::SLOW_PRESCALE - 1)) begin
      if (s_reg.scnt == 16'(SLOW_MOD)) begin
        s_next.scnt = 16'h0000;
        s_next.flags[pats_pkg::F_SLOW] = 1'b1;
      end else begin
        s_next.scnt = s_reg.scnt + 16'h0001;
      end
    end

    // SPI master, mode 0, select high while busy
    if (s_reg.busy) begin
      s_next.sdv = s_reg.sdv + 5'h01;
      if (s_reg.sdv == 5'(pats_pkg::SPI_HALF_CYC - 1)) begin
        s_next.sdv = 5'h00;
        s_next.sclk = ~s_reg.sclk;
        if (!s_reg.sclk) begin
          s_next.rx = {s_reg.rx[6:0], s_reg.miso_s2};
        end else begin
          s_next.tx = {s_reg.tx[6:0], 1'b0};
          s_next.bitc = s_reg.bitc + 3'h1;
          if (s_reg.bitc == 3'h7) begin
            s_next.busy = 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.ctrl <= pats_pkg::CTRL_RST;
      s_reg.start <= pats_pkg::START_RST;
      s_reg.end_v <= pats_pkg::END_RST;
      s_reg.cnt <= pats_pkg::START_RST;
      s_reg.duty <= {3{pats_pkg::DUTY_RST}};
      s_reg.dead <= DEAD_RST;
      s_reg.pt0 <= 16'(pats_pkg::PRETRIG0_CYC);
      s_reg.idly <= pats_pkg::IDLY_RST;
      s_reg.mask <= pats_pkg::MASK_RST;
      s_reg.dac <= pats_pkg::DAC_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata = s_reg.prdata;
  assign pready = acc;
  assign pslverr = acc && s_reg.err;
  assign dac_code = s_reg.dac;
  assign pwm_out = s_reg.pwm;
  assign reload_trigger = s_reg.trig;
  assign adc_start = s_reg.start_p;
  assign adc_seq = s_reg.seq;
  assign adc_clk_div = s_reg.ctrl[pats_pkg::C_CAL] ? pats_pkg::ADC_DIV_CAL : pats_pkg::ADC_DIV_NORM;
  assign adc_avg_samples = s_reg.ctrl[pats_pkg::C_CAL] ? pats_pkg::AVG_CAL : pats_pkg::AVG_NORM;
  assign fast_loop_irq = s_reg.flags[pats_pkg::F_FAST];
  assign delay_irq = s_reg.flags[pats_pkg::F_DLY] | s_reg.flags[pats_pkg::F_SEQ];
  assign slow_irq = s_reg.flags[pats_pkg::F_SLOW];
  assign spi_sclk = s_reg.sclk;
  assign spi_mosi = s_reg.tx[7];
  assign spi_cs1 = s_reg.busy;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_period_wrap: assert property ($signed(s_reg.cnt) >= $signed(s_reg.end_v) |=>
    s_reg.reload && s_reg.cnt == $past(s_reg.start)) else $error("counter did not wrap");
  a_spare_idle: assert property (pwm_out[7:6] == idle_pat[7:6] || $changed(idle_pat))
    else $error("spare channels active");
  a_pair_excl: assert property (!((pwm_out[0] ^ idle_pat[0]) && (pwm_out[1] ^ idle_pat[1])))
    else $error("pair 0 both sides active");
  a_fault_off: assert property (s_reg.fault_lat && $stable(idle_pat) |=> pwm_out == idle_pat)
    else $error("outputs on during fault");
  a_dead_gap: assert property ($changed(s_reg.raw[1]) && s_reg.dead != 16'h0000 |=>
    pwm_out[3:2] == idle_pat[3:2]) else $error("no dead time on pair 1");
  a_trig_gate: assert property (reload_trigger |-> s_reg.reload
    && $past(s_reg.ctrl[pats_pkg::C_TRIG_EN])) else $error("ungated reload trigger");
  a_dly_restart: assert property (reload_trigger |=> s_reg.dcnt == 16'h0000 && s_reg.drun)
    else $error("delay block not restarted");
  a_pretrig0: assert property (s_reg.drun && s_reg.dcnt == s_reg.pt0 |=>
    adc_start == 2'b11 && adc_seq == 2'b00) else $error("pre-trigger 0 missing");
  a_b2b_start: assert property (adc_done[0] && !adc_seq[0] && s_reg.ctrl[pats_pkg::C_B2B]
    && !(s_reg.drun && s_reg.dcnt == s_reg.pt0) |=> adc_start[0] && adc_seq[0])
    else $error("back-to-back start missing");
  a_fast_irq: assert property (adc_done[0] && !adc_seq[0] |=> fast_loop_irq)
    else $error("fast-loop request missing");
  a_seq_err: assert property (s_reg.drun && s_reg.dcnt == s_reg.pt0 && s_reg.unread[0]
    && !(acc && !pwrite && paddr == 8'h40) |=> delay_irq && s_reg.flags[pats_pkg::F_SEQ])
    else $error("sequence error not flagged");
  a_delay_irq: assert property (s_reg.drun && s_reg.dcnt == s_reg.idly && !s_reg.trig
    |=> delay_irq && !s_reg.drun) else $error("delay request missing");
  a_filter_four: assert property ($changed(s_reg.cmp_filt) |->
    $past(s_reg.cmp_s2, 1) == s_reg.cmp_filt && $past(s_reg.cmp_s2, 2) == s_reg.cmp_filt
    && $past(s_reg.cmp_s2, 3) == s_reg.cmp_filt
    && $past(s_reg.cmp_s2, 4) == s_reg.cmp_filt) else $error("filter flipped early");
  a_spi_frame: assert property ($rose(spi_cs1) |-> spi_cs1 [*8] ##1 !spi_sclk)
    else $error("spi select dropped early");

  c_trigger: cover property (reload_trigger);
  c_b2b: cover property (adc_done[0] && !adc_seq[0] ##1 adc_start[0]);
  c_seq_err: cover property ($rose(s_reg.flags[pats_pkg::F_SEQ]));
  c_fault: cover property ($rose(s_reg.fault_lat) ##[1:1000] $fell(s_reg.fault_lat));

endmodule

// ===== testbench/pats_adc_model.sv
// Converter pair model answering each start after a fixed conversion time
module pats_adc_model #(
  parameter int LAT = 6
) (
  input logic clk,
  input logic [1:0] start,
  input logic [1:0] seq,
  output logic [1:0] done,
  output logic [11:0] data0,
  output logic [11:0] data1
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt [2] = '{0, 0};
  logic [11:0] res [2] = '{12'h000, 12'h000};
  initial done = 2'h0;
  // ==========================================================================
  // Conversion timing
  // convert only when started
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      done[i] <= (cnt[i] == 1);
      if (start[i]) begin
        cnt[i] <= LAT;
        res[i] <= {4'h0, seq[i] ? 4'hb : 4'ha, 4'(i + 1)};
      end else if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
      end else begin
        res[i] <= ~res[i];
      end
    end
  end
  assign data0 = res[0];
  assign data1 = res[1];
endmodule

// ===== testbench/pwm_adc_trigger_sync_test.sv
// Self-checking bench for the PWM and converter trigger block
module pwm_adc_trigger_sync_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, fault_pin, cmp_raw, spi_miso;
  logic reload_trigger, fast_loop_irq, delay_irq, slow_irq, spi_sclk, spi_mosi, spi_cs1;
  logic [1:0] adc_start, adc_seq, adc_done;
  logic [7:0] paddr, pwm_out, rxs = 8'h00;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] adc_data0, adc_data1;
  logic [5:0] dac_code, adc_avg_samples;
  logic [4:0] adc_clk_div;
  int bad_count = 0, samples_checked = 0, cycles = 0, nbits = 0, n, t0;
  localparam logic [39:0] ROWS [8] = '{{8'h00, 32'h1d1}, {8'h04, 32'hf448}, {8'h08, 32'hbb7},
    {8'h18, 32'h32}, {8'h1c, 32'h19}, {8'h20, 32'h2328}, {8'h24, 32'hc0}, {8'h28, 32'h3e}};
  // ==========================================================================
  // Design and partner
  pats_top #(.SLOW_MOD(5)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_pin(fault_pin), .cmp_raw(cmp_raw), .dac_code(dac_code),
    .pwm_out(pwm_out), .reload_trigger(reload_trigger), .adc_start(adc_start),
    .adc_seq(adc_seq), .adc_done(adc_done), .adc_data0(adc_data0), .adc_data1(adc_data1),
    .adc_clk_div(adc_clk_div), .adc_avg_samples(adc_avg_samples),
    .fast_loop_irq(fast_loop_irq), .delay_irq(delay_irq), .slow_irq(slow_irq),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_cs1(spi_cs1), .spi_miso(spi_miso));
  pats_adc_model adc (.clk(pclk), .start(adc_start), .seq(adc_seq), .done(adc_done),
    .data0(adc_data0), .data1(adc_data1));
  // Driver echo keeps the receive path busy
  assign spi_miso = spi_mosi;
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Index: 0 trig, 1 start, 2 done, 3 delay, 4 select, 5 slow, 6 pwm
  function automatic logic pick(int w);
    logic [6:0] v;
    v = {|pwm_out[5:0], slow_irq, spi_cs1, delay_irq, adc_done[0], adc_start[0], reload_trigger};
    return v[w];
  endfunction
  task automatic wait_for(input int w, input logic lvl);
    n = 0;
    while (pick(w) !== lvl) begin
      @(posedge pclk);
      n++;
    end
  endtask
  always @(posedge spi_sclk) begin
    if (spi_cs1) begin
      rxs <= {rxs[6:0], spi_mosi};
      nbits <= nbits + 1;
    end
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      stop_test();
    end
    if (presetn === 1'b1) begin
      chk("spare pins", 32'h0, 32'(pwm_out[7:6]));
      chk("pair overlap", 32'h0, 32'(pwm_out[5:0] & (pwm_out[5:0] >> 1) & 6'h15));
    end
  end
  // ==========================================================================
  // Scenarios
  initial begin
    {psel, penable, pwrite, paddr, pwdata, fault_pin, cmp_raw, presetn} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("dac", 32'h3e, 32'(dac_code));
    foreach (ROWS[i]) begin
      apb(1'b0, ROWS[i][39:32], 32'h0);
      chk("reset value", 32'(ROWS[i][15:0]), 32'(rd[15:0]));
    end
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    apb(1'b1, 8'h04, 32'hffffff9c);
    apb(1'b1, 8'h08, 32'h63);
    apb(1'b1, 8'h20, 32'h12c);
    wait_for(0, 1'b1);
    t0 = cycles;
    wait_for(1, 1'b1);
    chk("pre-trigger delay", pats_pkg::PRETRIG0_CYC + 2, n);
    chk("first sequence", 32'h0, 32'(adc_seq));
    wait_for(2, 1'b1);
    @(posedge pclk);
    chk("back to back", 32'hf, 32'({adc_start, adc_seq}));
    chk("fast irq", 32'h1, 32'(fast_loop_irq));
    apb(1'b1, 8'h00, 32'h1d0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(8'h40 + 4 * i), 32'h0);
      chk("result", {24'h0, i[0] ? 4'hb : 4'ha, 4'(i / 2 + 1)}, rd);
    end
    wait_for(3, 1'b1);
    chk("delay time", 32'h12c + 2, cycles - t0);
    apb(1'b0, 8'h2c, 32'h0);
    chk("flags", 32'h6, 32'(rd[2:0]));
    apb(1'b1, 8'h2c, 32'h1f);
    apb(1'b1, 8'h00, 32'h1d1);
    chk("irq cleared", 32'h0, 32'({fast_loop_irq, delay_irq}));
    wait_for(3, 1'b1);
    apb(1'b0, 8'h2c, 32'h0);
    chk("sequence error", 32'h1, 32'(rd[0]));
    apb(1'b1, 8'h00, 32'h1f0);
    @(posedge pclk);
    chk("calibration", 32'h420, 32'({adc_clk_div, adc_avg_samples}));
    apb(1'b1, 8'h00, 32'h1d0);
    @(posedge pclk);
    chk("normal clock", 32'h101, 32'({adc_clk_div, adc_avg_samples}));
    apb(1'b1, 8'h30, 32'ha5);
    wait_for(4, 1'b1);
    chk("select soon", 32'h1, 32'(n < 8));
    wait_for(4, 1'b0);
    chk("spi bits", 32'h8a5, {nbits[23:0], rxs});
    apb(1'b0, 8'h30, 32'h0);
    chk("spi echo", 32'ha5, rd);
    fault_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("fault off", 32'h0, 32'(pwm_out));
    fault_pin <= 1'b0;
    wait_for(6, 1'b1);
    chk("fault clear", 32'h1, 32'(n < 300));
    apb(1'b1, 8'h00, 32'h1d2);
    repeat (6) @(posedge pclk);
    chk("fault low", 32'h0, 32'(pwm_out));
    apb(1'b1, 8'h00, 32'h1d0);
    cmp_raw <= 1'b1;
    repeat (3) @(posedge pclk);
    cmp_raw <= 1'b0;
    apb(1'b0, 8'h2c, 32'h0);
    chk("filter short", 32'h0, 32'(rd[5]));
    cmp_raw <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, 8'h2c, 32'h0);
    chk("filter long", 32'h1, 32'(rd[5]));
    cmp_raw <= 1'b0;
    chk("slow flag", 32'h1, 32'(slow_irq));
    apb(1'b1, 8'h2c, 32'h8);
    repeat (2) @(posedge pclk);
    wait_for(5, 1'b1);
    chk("slow period", 32'h1, 32'(n < 97));
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset outputs", 32'h7d, 32'({pwm_out, dac_code, adc_clk_div == 5'h4}));
    stop_test();
  end
endmodule
